// ===== core/tcc_top.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tcc_top #(
    parameter int unsigned ADDR_W = 12 // apb address width
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire tcc_pkg::tcc_cnt_s cnt_in,        // shared counter
    input  wire logic [1:0]        chan_pin_i,    // pin levels
    output logic      [1:0]        chan_pin_o,    // driven levels
    output logic      [1:0]        chan_pin_oe_n, // low: driving
    output logic      [1:0]        chan_port_ctl, // pin to port
    output logic      [1:0]        chan_irq       // per channel
);
    // the decoder compares 12-bit offsets
    if (ADDR_W < 5 || ADDR_W > 12) begin : g_chk
        $error("ADDR_W must be 5 to 12");
    end

    // all block state
    typedef struct packed {
        logic [1:0]                   sync1;    // pin stage one
        logic [1:0]                   sync2;    // pin stage two
        tcc_pkg::tcc_ctrl_s [1:0]     ctrl;     // control bytes
        logic [1:0][15:0]             val;      // value registers
        logic [1:0]                   arm;      // flag clear armed
        logic [1:0]                   cap_lock; // capture held
        logic [1:0]                   cmp_lock; // compare held
        logic                         bsel;     // buffered source
        logic [31:0]                  rdata;    // read data
    } tcc_st_s;

    tcc_st_s                  q, d;
    tcc_pkg::tcc_dec_s        dec;      // decoded address
    tcc_pkg::tcc_ctrl_s [1:0] ctrl_eff; // control as seen
    tcc_pkg::tcc_ctrl_s       nc;       // control being written
    logic                     dis1;     // channel 1 disabled
    logic                     setup;    // apb setup phase
    logic                     acc;      // apb access phase
    logic                     wr;       // write completes
    logic                     rd;       // read completes
    logic [1:0]               capm;     // capture-mode channels
    logic [1:0]               lock;     // byte-pair locks
    logic [1:0][15:0]         cmp_val;  // compare sources
    logic [1:0]               cap_evt;  // capture pulses
    logic [1:0]               cmp_evt;  // compare pulses
    logic [1:0]               pin_drv;  // channel drives pin
    logic [1:0]               pin_o;    // channel pin levels

    // address decode, used for the read and the write
    function automatic tcc_pkg::tcc_dec_s decode(
        input logic [11:0] a
    );
        tcc_pkg::tcc_dec_s r;
        r = '0;
        r.hit = 1'b1;
        unique case (a)
            tcc_pkg::OFF_CH0_CTRL: r.kind = tcc_pkg::K_CTRL;
            tcc_pkg::OFF_CH0_HI:   r.kind = tcc_pkg::K_HI;
            tcc_pkg::OFF_CH0_LO:   r.kind = tcc_pkg::K_LO;
            tcc_pkg::OFF_CH1_CTRL: begin
                r.ch   = 1'b1;
                r.kind = tcc_pkg::K_CTRL;
            end
            tcc_pkg::OFF_CH1_HI: begin
                r.ch   = 1'b1;
                r.kind = tcc_pkg::K_HI;
            end
            tcc_pkg::OFF_CH1_LO: begin
                r.ch   = 1'b1;
                r.kind = tcc_pkg::K_LO;
            end
            default: r.hit = 1'b0; // unmapped word
        endcase
        return r;
    endfunction

    // bus phases; zero wait state at access
    always_comb begin
        dec   = decode(12'(paddr));
        setup = psel && !penable;
        acc   = psel && penable;
        wr    = acc && pwrite;
        rd    = acc && !pwrite;
    end

    assign pready  = 1'b1;
    assign pslverr = acc && !dec.hit; // unmapped answers error
    assign prdata  = q.rdata;

    // channel view of the control bytes
    always_comb begin
        dis1        = q.ctrl[0].buffered_mode_sel;
        ctrl_eff[0] = q.ctrl[0];
        // a disabled register reads zero and acts as all-off
        ctrl_eff[1] = dis1 ? tcc_pkg::tcc_ctrl_s'(tcc_pkg::CTRL_RST)
                           : q.ctrl[1];
        for (int i = 0; i < 2; i++) begin
            // msb:msa = 0:0 is capture; anything else is compare
            capm[i] = !dis1 && !ctrl_eff[i].mode_sel_a;
            lock[i] = q.cap_lock[i] || q.cmp_lock[i];
        end
    end

    // compare sources; buffered pair alternates per period
    always_comb begin
        cmp_val[0] = q.val[0];
        cmp_val[1] = q.val[1];
        if (dis1 && q.bsel) begin
            cmp_val[0] = q.val[1];
        end
    end

    // interrupt gate per channel
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            chan_irq[i] = ctrl_eff[i].chan_event_flag
                && ctrl_eff[i].chan_irq_enable;
        end
    end

    // the two channels and their pin wiring
    for (genvar g = 0; g < 2; g++) begin : g_ch
        logic g_lock; // lock seen by this channel
        // buffered channel 0 obeys the lock of its live source
        assign g_lock = (g == 0 && dis1) ? lock[q.bsel] : lock[g];
        tcc_chan u_chan (
            .pclk     (pclk),
            .presetn  (presetn),
            .ctrl     (ctrl_eff[g]),
            .buf_mode (g == 0 && dis1),
            .cmp_val  (cmp_val[g]),
            .lock     (g_lock),
            .cnt      (cnt_in),
            .pin_s    (q.sync2[g]),
            .cap_evt  (cap_evt[g]),
            .cmp_evt  (cmp_evt[g]),
            .pin_o    (pin_o[g]),
            .pin_drv  (pin_drv[g])
        );
        assign chan_pin_o[g]    = pin_o[g];
        assign chan_pin_oe_n[g] = !pin_drv[g];
        assign chan_port_ctl[g] = !pin_drv[g];
    end

    // next state
    always_comb begin
        d       = q;
        nc      = tcc_pkg::tcc_ctrl_s'(pwdata[7:0]);
        // two flops before anything looks at the pins
        d.sync1 = chan_pin_i;
        d.sync2 = q.sync1;

        // read data is fetched in setup, so the byte read and
        // the flag seen by the clear sequence are one value
        if (setup && !pwrite) begin
            d.rdata = 32'h0000_0000;
            if (dec.hit) begin
                unique case (dec.kind)
                    tcc_pkg::K_CTRL: d.rdata[7:0] = ctrl_eff[dec.ch];
                    tcc_pkg::K_HI:
                        d.rdata[7:0] = q.val[dec.ch][15:8];
                    default: d.rdata[7:0] = q.val[dec.ch][7:0];
                endcase
            end
        end

        // read side effects at the completing edge
        if (rd && dec.hit) begin
            unique case (dec.kind)
                tcc_pkg::K_CTRL: begin
                    // arm the clear only when the flag was seen set
                    if (q.rdata[7]) begin
                        d.arm[dec.ch] = 1'b1;
                    end
                end
                tcc_pkg::K_HI: begin
                    if (capm[dec.ch]) begin
                        d.cap_lock[dec.ch] = 1'b1;
                    end
                end
                default: d.cap_lock[dec.ch] = 1'b0;
            endcase
        end

        // writes; the disabled control byte ignores them
        if (wr && dec.hit) begin
            unique case (dec.kind)
                tcc_pkg::K_CTRL: begin
                    if (!(dec.ch && dis1)) begin
                        // writing one keeps the flag; zero clears
                        // only after the arming read
                        nc.chan_event_flag =
                            q.ctrl[dec.ch].chan_event_flag
                            && !(q.arm[dec.ch]
                            && !pwdata[7]);
                        if (dec.ch) begin
                            nc.buffered_mode_sel = 1'b0;
                        end
                        d.ctrl[dec.ch] = nc;
                        d.arm[dec.ch]  = 1'b0;
                    end
                end
                tcc_pkg::K_HI: begin
                    d.val[dec.ch][15:8] = pwdata[7:0];
                    if (!capm[dec.ch]) begin
                        d.cmp_lock[dec.ch] = 1'b1;
                    end
                end
                default: begin
                    d.val[dec.ch][7:0]  = pwdata[7:0];
                    d.cmp_lock[dec.ch] = 1'b0;
                end
            endcase
        end

        // hardware events last, so a set beats a same-cycle clear
        for (int i = 0; i < 2; i++) begin
            if (cap_evt[i]) begin
                d.val[i] = cnt_in.value;
            end
            if (cap_evt[i] || cmp_evt[i]) begin
                d.ctrl[i].chan_event_flag = 1'b1;
                // a new event cancels a pending clear
                d.arm[i] = 1'b0;
            end
        end

        // buffered source flips at each overflow
        if (!dis1) begin
            d.bsel = 1'b0;
        end else if (cnt_in.ovf) begin
            d.bsel = !q.bsel;
        end
    end

    // state register; value bytes are cleared too, harmless
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    a_irq_gate: assert property (@(posedge pclk)
        disable iff (!presetn)
        chan_irq[0] |-> q.ctrl[0].chan_irq_enable
        && q.ctrl[0].chan_event_flag)
        else $error("irq without enable");
    a_buf_bit_ch1: assert property (@(posedge pclk)
        disable iff (!presetn) !q.ctrl[1].buffered_mode_sel)
        else $error("buffered bit in channel 1");
    a_ch1_released: assert property (@(posedge pclk)
        disable iff (!presetn)
        q.ctrl[0].buffered_mode_sel |-> chan_port_ctl[1]
        && chan_pin_oe_n[1] && !chan_irq[1])
        else $error("channel 1 still active");
    a_cap_hold: assert property (@(posedge pclk)
        disable iff (!presetn)
        q.cap_lock[0] && !wr && !(rd && dec.hit && !dec.ch
        && dec.kind == tcc_pkg::K_LO) |=> $stable(q.val[0]))
        else $error("capture during byte lock");
    a_cmp_hold: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr && dec.hit && !dec.ch && dec.kind == tcc_pkg::K_HI
        && !capm[0] && !dis1 |=> !cmp_evt[0])
        else $error("compare during byte lock");
    a_flag_set: assert property (@(posedge pclk)
        disable iff (!presetn)
        cap_evt[0] || cmp_evt[0] |=> q.ctrl[0].chan_event_flag)
        else $error("event flag not set");
endmodule // tcc_top
`default_nettype wire

// ===== include/tcc_pkg.sv
// Notes on behaviour
// - irq only forwarded while enable bit set
// - buffered select bit lives in channel 0 only
// - buffered mode disables channel 1 control, frees pin
// - mode bit a: capture or unbuffered compare
// - edge field zero: mode bit a gives preset
// - edge field zero leaves pin to port
// - capture edge: rising, falling or both
// - compare action: none, toggle, clear, set
// - buffered mode uses same compare actions
// - overflow toggles pin in compare mode
// - overflow action beats simultaneous compare
// - max duty, with overflow toggle set, forces full duty next period
// - polarity decides the full duty level
// - value register holds capture or compare value
// - high byte read blocks captures until low
// - high byte write blocks compares until low
// - flag set by event, cleared read-then-zero
// - counter overflow marks the period boundary
`default_nettype none
package tcc_pkg;
    // byte offsets of the channel registers, one word each
    localparam logic [11:0] OFF_CH0_CTRL = 12'h000;
    localparam logic [11:0] OFF_CH0_HI   = 12'h004;
    localparam logic [11:0] OFF_CH0_LO   = 12'h008;
    localparam logic [11:0] OFF_CH1_CTRL = 12'h00c;
    localparam logic [11:0] OFF_CH1_HI   = 12'h010;
    localparam logic [11:0] OFF_CH1_LO   = 12'h014;
    // values after reset
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [15:0] VAL_RST  = 16'h0000;
    // edge/level field codes
    localparam logic [1:0] ELS_OFF  = 2'h0;
    localparam logic [1:0] ELS_LO   = 2'h1; // rising / toggle
    localparam logic [1:0] ELS_HI   = 2'h2; // falling / clear
    localparam logic [1:0] ELS_BOTH = 2'h3; // both / set
    // register kinds inside a channel
    localparam logic [1:0] K_CTRL = 2'h0;
    localparam logic [1:0] K_HI   = 2'h1;
    localparam logic [1:0] K_LO   = 2'h2;

    // channel control byte, msb first
    typedef struct packed {
        logic       chan_event_flag;   // bit 7
        logic       chan_irq_enable;   // bit 6
        logic       buffered_mode_sel; // bit 5
        logic       mode_sel_a;        // bit 4
        logic [1:0] edge_level_sel;    // bits 3:2 (hi, lo)
        logic       toggle_on_overflow; // bit 1
        logic       max_duty_force;    // bit 0
    } tcc_ctrl_s;

    // shared counter view, same clock
    typedef struct packed {
        logic [15:0] value;        // counter value
        logic        ovf;          // one-cycle overflow pulse
        logic        counter_halt; // counter stopped
    } tcc_cnt_s;

    // decoded register address
    typedef struct packed {
        logic       hit;  // mapped
        logic       ch;   // channel number
        logic [1:0] kind; // ctrl, hi or lo
    } tcc_dec_s;
endpackage
`default_nettype wire

// ===== core/tcc_chan.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_chan (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire tcc_pkg::tcc_ctrl_s ctrl,     // effective control
    input  wire logic              buf_mode, // buffered pair active
    input  wire logic [15:0]       cmp_val,  // compare value
    input  wire logic              lock,     // byte-pair lock
    input  wire tcc_pkg::tcc_cnt_s cnt,      // counter view
    input  wire logic              pin_s,    // synchronised pin
    output logic                   cap_evt,  // capture pulse
    output logic                   cmp_evt,  // compare pulse
    output logic                   pin_o,    // pin level
    output logic                   pin_drv   // channel owns pin
);
    // all channel state
    typedef struct packed {
        logic pin_prev; // last pin sample
        logic eq_q;     // last equality
        logic out_q;    // pin level
        logic max_q;    // max duty, period aligned
    } tcc_ch_s;

    tcc_ch_s q, d;
    logic    off;      // field cleared
    logic    cap_mode; // input capture
    logic    cmp_mode; // compare driving the pin
    logic    sw_cmp;   // compare without pin
    logic    eq;       // counter equals value
    logic    pol;      // pwm polarity
    logic    rise;     // rising edge seen
    logic    fall;     // falling edge seen

    // mode decoding
    always_comb begin
        off      = (ctrl.edge_level_sel == tcc_pkg::ELS_OFF);
        cap_mode = !off && !ctrl.mode_sel_a && !buf_mode;
        cmp_mode = !off && (ctrl.mode_sel_a || buf_mode);
        sw_cmp   = off && ctrl.mode_sel_a;
        // clear-on-compare starts high, so it is polarity one
        pol      = !ctrl.edge_level_sel[0];
        rise     = pin_s && !q.pin_prev;
        fall     = !pin_s && q.pin_prev;
        eq       = (cnt.value == cmp_val);
    end

    // events; halt and byte lock both stop captures
    always_comb begin
        cap_evt = cap_mode && !lock && !cnt.counter_halt
            && ((ctrl.edge_level_sel[0] && rise)
            || (ctrl.edge_level_sel[1] && fall));
        // only the first cycle of equality counts
        cmp_evt = (cmp_mode || sw_cmp) && eq && !q.eq_q
            && !lock;
    end

    // next pin level
    always_comb begin
        d          = q;
        d.pin_prev = pin_s;
        d.eq_q     = eq;
        if (off) begin
            d.out_q = !ctrl.mode_sel_a;
            d.max_q = 1'b0;
        end else if (cmp_mode) begin
            if (cnt.ovf) begin
                d.max_q = ctrl.max_duty_force;
            end
            if (ctrl.toggle_on_overflow && d.max_q) begin
                d.out_q = pol;
            end else if (cnt.ovf && ctrl.toggle_on_overflow) begin
                d.out_q = !q.out_q;
            end else if (cmp_evt) begin
                unique case (ctrl.edge_level_sel)
                    tcc_pkg::ELS_LO: d.out_q = !q.out_q;
                    tcc_pkg::ELS_HI: d.out_q = 1'b0;
                    default:         d.out_q = 1'b1;
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pin_o   = q.out_q;
    assign pin_drv = cmp_mode;

    // the release edge itself still loads the reset level, so skip it
    a_preset_level: assert property (@(posedge pclk)
        disable iff (!presetn)
        off && $past(presetn) |=> pin_o == !$past(ctrl.mode_sel_a))
        else $error("preset level wrong");
    a_ovf_toggle: assert property (@(posedge pclk)
        disable iff (!presetn)
        cmp_mode && ctrl.toggle_on_overflow && cnt.ovf
        && !ctrl.max_duty_force |=> pin_o != $past(pin_o))
        else $error("overflow toggle missed");
    a_capture_edge: assert property (@(posedge pclk)
        disable iff (!presetn)
        cap_mode && !lock && !cnt.counter_halt
        && ctrl.edge_level_sel == tcc_pkg::ELS_LO && pin_s
        && !$past(pin_s) |-> cap_evt)
        else $error("rising edge not captured");
    a_max_level: assert property (@(posedge pclk)
        disable iff (!presetn)
        cmp_mode && ctrl.toggle_on_overflow && q.max_q && !cnt.ovf
        ##1 cmp_mode |-> pin_o == $past(pol))
        else $error("max duty level wrong");
endmodule // tcc_chan
`default_nettype wire

// ===== sim/tcc_pins.sv
`timescale 1ns/1ps
`default_nettype none
// outside source on the two channel pins
module tcc_pins (
    input  wire logic [1:0] ext_lvl,  // level forced from outside
    input  wire logic [1:0] pin_o,    // level from the block
    input  wire logic [1:0] pin_oe_n, // low: block drives
    output logic      [1:0] pin_lvl   // resolved wire level
);
    // outside source backs off where the block drives, avoiding a clash
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_lvl[i] = pin_oe_n[i] ? ext_lvl[i] : pin_o[i];
        end
    end
endmodule // tcc_pins
`default_nettype wire

// ===== sim/tcc_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_tb;
    logic              pclk       = 1'b0;  // 100 mhz bus clock
    logic              presetn    = 1'b0;  // held low at start
    logic [11:0]       paddr      = 12'h000;
    logic              psel       = 1'b0;
    logic              penable    = 1'b0;
    logic              pwrite     = 1'b0;
    logic [31:0]       pwdata     = 32'h0;
    tcc_pkg::tcc_cnt_s cnt        = '0;    // counter view, parked at 0
    logic [1:0]        ext        = 2'h0;  // outside pin level
    logic [31:0]       prdata;             // read data
    logic              pready;             // slave answer
    logic              pslverr;            // slave error
    logic [1:0]        pin_i;              // resolved pins
    logic [1:0]        pin_o;              // block pin levels
    logic [1:0]        oe_n;               // low: block drives
    logic [1:0]        port;               // pin left to port
    logic [1:0]        irq;                // channel requests
    logic [31:0]       rd;                 // last read word
    logic              err;                // last pslverr
    logic [15:0]       rnd        = 16'h0008; // lfsr state
    logic [15:0]       v;                  // random value
    logic [15:0]       b;                  // second value
    int                num_errors = 0;
    int                n_tests    = 0;

    tcc_top #(.ADDR_W(12)) tcc_top_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cnt_in(cnt), .chan_pin_i(pin_i), .chan_pin_o(pin_o),
        .chan_pin_oe_n(oe_n), .chan_port_ctl(port), .chan_irq(irq));
    tcc_pins tcc_pins_i (.ext_lvl(ext), .pin_o(pin_o), .pin_oe_n(oe_n),
        .pin_lvl(pin_i));

    // free-running clock
    always #5 pclk = ~pclk;

    // next random value; never zero, so never the parked counter
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask

    // one apb transfer; waits for pready, unbounded
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // no fixed wait: only the watchdog ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // control write with the counter halted around it
    task automatic wctl(input logic [11:0] a, input logic [7:0] d);
        cnt.counter_halt <= 1'b1;
        apb(1'b1, a, d);
        cnt.counter_halt <= 1'b0;
        // let the new mode reach the pin before anyone looks
        repeat (2) @(posedge pclk);
    endtask

    // read the control byte, compare its flag
    task automatic fl(input logic [11:0] a, input logic e);
        apb(1'b0, a, 8'h00);
        chk("flag", e, rd[7]);
    endtask

    // read then write zero to the flag
    task automatic clr(input logic [11:0] a);
        apb(1'b0, a, 8'h00);
        apb(1'b1, a, rd[7:0] & 8'h7f);
    endtask

    // one cycle of counter value and overflow, then settle
    task automatic tick(input logic [15:0] c, input logic o);
        @(posedge pclk);
        cnt.value <= c;
        cnt.ovf   <= o;
        @(posedge pclk);
        cnt.value <= 16'h0000;
        cnt.ovf   <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    task automatic wval(input logic [11:0] h, input logic [15:0] d);
        apb(1'b1, h, d[15:8]);
        apb(1'b1, h + 12'h004, d[7:0]);
    endtask

    task automatic test_done;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run
    initial begin
        #300000;
        num_errors++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, tcc_pkg::OFF_CH0_CTRL, 8'h00);
        chk("ctrl0 reset", 32'h0, rd);
        chk("port reset", 2'h3, port);
        chk("irq reset", 2'h0, irq);
        chk("preset high", 2'h3, pin_o);
        apb(1'b0, 12'h0f0, 8'h00);
        chk("unmapped err", 1'b1, err);
        chk("unmapped rd", 32'h0, rd);
        // unbuffered compare, every action, with the byte lock
        for (int k = 1; k < 4; k++) begin
            v = lfsr(rnd);
            rnd = v;
            wval(tcc_pkg::OFF_CH0_HI, v);
            wctl(tcc_pkg::OFF_CH0_CTRL, (k == 3) ? 8'h10 : 8'h00);
            chk("preset", k != 3, pin_o[0]);
            chk("port preset", 1'b1, port[0]);
            // software compare flags a match but leaves the pin alone
            tick(v, 1'b0);
            fl(tcc_pkg::OFF_CH0_CTRL, k == 3);
            chk("sw cmp pin", k != 3, pin_o[0]);
            clr(tcc_pkg::OFF_CH0_CTRL);
            wctl(tcc_pkg::OFF_CH0_CTRL, {4'h5, k[1:0], 2'h0});
            chk("oe_n", 1'b0, oe_n[0]);
            apb(1'b1, tcc_pkg::OFF_CH0_HI, v[15:8]);
            tick(v, 1'b0);
            fl(tcc_pkg::OFF_CH0_CTRL, 1'b0);
            apb(1'b1, tcc_pkg::OFF_CH0_LO, v[7:0]);
            tick(v, 1'b0);
            chk("cmp pin", k == 3, pin_o[0]);
            chk("irq on", 1'b1, irq[0]);
            wctl(tcc_pkg::OFF_CH0_CTRL, {4'h1, k[1:0], 2'h0});
            chk("irq off", 1'b0, irq[0]);
            fl(tcc_pkg::OFF_CH0_CTRL, 1'b1);
            clr(tcc_pkg::OFF_CH0_CTRL);
            fl(tcc_pkg::OFF_CH0_CTRL, 1'b0);
        end
        // overflow toggle beats a set action at the same time
        wctl(tcc_pkg::OFF_CH0_CTRL, 8'h00);
        wctl(tcc_pkg::OFF_CH0_CTRL, 8'h1e);
        tick(v, 1'b1);
        chk("ovf wins", 1'b0, pin_o[0]);
        tick(~v, 1'b1);
        chk("ovf toggle", 1'b1, pin_o[0]);
        // full duty, clear action means polarity one
        wctl(tcc_pkg::OFF_CH0_CTRL, 8'h1b);
        tick(~v, 1'b1);
        tick(v, 1'b0);
        chk("max duty", 1'b1, pin_o[0]);
        // capture on channel 1, every edge choice
        for (int k = 1; k < 4; k++) begin
            wctl(tcc_pkg::OFF_CH1_CTRL, {4'h0, k[1:0], 2'h0});
            clr(tcc_pkg::OFF_CH1_CTRL);
            for (int s = 0; s < 2; s++) begin
                v = lfsr(rnd);
                rnd = v;
                cnt.value <= v;
                ext[1] <= ~ext[1];
                repeat (6) @(posedge pclk);
                cnt.value <= 16'h0000;
                fl(tcc_pkg::OFF_CH1_CTRL, k[s]);
                if (k[s]) begin
                    apb(1'b0, tcc_pkg::OFF_CH1_HI, 8'h00);
                    chk("cap hi", v[15:8], rd);
                    apb(1'b0, tcc_pkg::OFF_CH1_LO, 8'h00);
                    chk("cap lo", v[7:0], rd);
                end
                clr(tcc_pkg::OFF_CH1_CTRL);
            end
        end
        // high byte read holds the pair against a new capture
        apb(1'b0, tcc_pkg::OFF_CH1_HI, 8'h00);
        cnt.value <= ~v;
        ext[1] <= 1'b1;
        repeat (6) @(posedge pclk);
        cnt.value <= 16'h0000;
        apb(1'b0, tcc_pkg::OFF_CH1_LO, 8'h00);
        chk("cap locked", v[7:0], rd);
        // buffered pair: channel 1 control gone, values alternate
        wctl(tcc_pkg::OFF_CH1_CTRL, 8'h20);
        apb(1'b0, tcc_pkg::OFF_CH1_CTRL, 8'h00);
        chk("ch1 no buf bit", 1'b0, rd[5]);
        v = lfsr(rnd);
        b = lfsr(v);
        rnd = b;
        wval(tcc_pkg::OFF_CH0_HI, v);
        wval(tcc_pkg::OFF_CH1_HI, b);
        // flag still set by the matches of the overflow scenarios
        clr(tcc_pkg::OFF_CH0_CTRL);
        wctl(tcc_pkg::OFF_CH0_CTRL, 8'h00);
        wctl(tcc_pkg::OFF_CH0_CTRL, 8'h24);
        wctl(tcc_pkg::OFF_CH1_CTRL, 8'h1c);
        apb(1'b0, tcc_pkg::OFF_CH1_CTRL, 8'h00);
        chk("ch1 disabled", 32'h0, rd);
        chk("ch1 to port", 1'b1, port[1]);
        apb(1'b0, tcc_pkg::OFF_CH0_CTRL, 8'h00);
        chk("ch0 buf bit", 8'h24, rd[7:0]);
        tick(v, 1'b0);
        chk("buf pin a", 1'b0, pin_o[0]);
        clr(tcc_pkg::OFF_CH0_CTRL);
        tick(16'h0000, 1'b1);
        tick(v, 1'b0);
        fl(tcc_pkg::OFF_CH0_CTRL, 1'b0);
        tick(b, 1'b0);
        fl(tcc_pkg::OFF_CH0_CTRL, 1'b1);
        chk("buf pin b", 1'b1, pin_o[0]);
        test_done();
    end
endmodule // tcc_tb
`default_nettype wire
